// ---- core/cmd_decoder.sv ----
// device end: command decoder and power-down state
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder
	import cmd_decode_pkg::*;
#(
	parameter int ZQ_LONG  = ZQ_LONG_CYCLES,
	parameter int ZQ_SHORT = ZQ_SHORT_CYCLES
) (
	// clock and reset
	input  wire logic            clock_i,
	input  wire logic            nrst_i,
	input  wire logic            ce_i,
	// link
	cmd_link_if.dev              link,
	// mode and bank state from the rest of the device
	input  wire logic [1:0]      mr0_bl_i,
	input  wire logic            banks_open_i,
	// decoded results
	output logic                 read_ap_o,
	output logic                 read_chop4_o,
	output logic [BANK_W-1:0]    bank_o,
	output logic                 mrs_o,
	output logic [1:0]           mrs_sel_o,
	output logic                 zq_long_o,
	output logic                 zq_short_o,
	output logic                 busy_o,
	output logic                 idle_o,
	output pwr_type              pwr_o
);
	typedef struct packed {
		logic              cke_prev;
		logic              read_ap;
		logic              chop4;
		logic [BANK_W-1:0] bank;
		logic              mrs;
		logic [1:0]        mrs_sel;
		logic              zq_long;
		logic              zq_short;
		logic [7:0]        busy_cnt;
		logic              busy;
		logic              idle;
		pwr_type           pwr;
	} state_type;

	state_type s_reg;
	state_type s_next;
	cmd_type   cmd;
	logic      nop_like;

	always_comb begin
		// odt deliberately unused
		cmd = CMD_OTHER;
		if (link.cs_n) begin
			cmd = CMD_NONE;
		end else if (!link.ras_n && !link.cas_n && !link.we_n) begin
			cmd = CMD_MRS;
		end else if (link.ras_n && !link.cas_n && link.we_n && link.addr[AP_BIT]) begin
			cmd = CMD_READ_AP;
		end else if (link.ras_n && link.cas_n && link.we_n) begin
			cmd = CMD_NONE;
		end else if (link.ras_n && link.cas_n && !link.we_n) begin
			cmd = link.addr[AP_BIT] ? CMD_ZQ_LONG : CMD_ZQ_SHORT;
		end
		nop_like = (cmd == CMD_NONE);
	end

	always_comb begin
		s_next = s_reg;
		s_next.cke_prev = link.cke;
		s_next.read_ap = 1'b0;
		s_next.mrs = 1'b0;
		s_next.zq_long = 1'b0;
		s_next.zq_short = 1'b0;
		if (s_reg.busy_cnt != 8'h00) begin
			s_next.busy_cnt = s_reg.busy_cnt - 8'h01;
		end
		unique case (s_reg.pwr)
			PWR_UP: begin
				if (s_reg.cke_prev && !link.cke) begin
					if (s_reg.idle) begin
						s_next.pwr = PWR_PRE_PD;
					end else if (nop_like) begin
						s_next.pwr = PWR_ACT_PD;
					end
				end else if (s_reg.cke_prev && link.cke) begin
					s_next.bank = link.ba;
					unique case (cmd)
						CMD_READ_AP: begin
							s_next.read_ap = 1'b1;
							unique case (mr0_bl_i)
								BL_OTF:    s_next.chop4 = !link.addr[BC_BIT];
								BL_FIXED4: s_next.chop4 = 1'b1;
								default:   s_next.chop4 = 1'b0;
							endcase
							s_next.busy_cnt = s_next.busy_cnt
								+ 8'(s_next.chop4 ? BURST4_CYCLES : BURST8_CYCLES);
						end
						CMD_MRS: begin
							s_next.mrs = 1'b1;
							s_next.mrs_sel = link.ba[1:0];
						end
						CMD_ZQ_LONG: begin
							s_next.zq_long = 1'b1;
							s_next.busy_cnt = s_next.busy_cnt + 8'(ZQ_LONG);
						end
						CMD_ZQ_SHORT: begin
							s_next.zq_short = 1'b1;
							s_next.busy_cnt = s_next.busy_cnt + 8'(ZQ_SHORT);
						end
						default: ;
					endcase
				end
			end
			PWR_ACT_PD, PWR_PRE_PD: begin
				if (!s_reg.cke_prev && link.cke && nop_like) begin
					s_next.pwr = PWR_UP;
				end
			end
			default: s_next.pwr = PWR_UP;
		endcase
		s_next.busy = (s_next.busy_cnt != 8'h00);
		s_next.idle = !banks_open_i && (s_next.busy_cnt == 8'h00) && link.cke
			&& (s_next.pwr == PWR_UP);
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_reg <= '{default: '0, pwr: PWR_UP};
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign read_ap_o    = s_reg.read_ap;
	assign read_chop4_o = s_reg.chop4;
	assign bank_o       = s_reg.bank;
	assign mrs_o        = s_reg.mrs;
	assign mrs_sel_o    = s_reg.mrs_sel;
	assign zq_long_o    = s_reg.zq_long;
	assign zq_short_o   = s_reg.zq_short;
	assign busy_o       = s_reg.busy;
	assign idle_o       = s_reg.idle;
	assign pwr_o        = s_reg.pwr;
endmodule : cmd_decoder
`default_nettype wire

// ---- common/cmd_decode_pkg.sv ----
// constants and types shared by both ends of the command link
package cmd_decode_pkg;
	localparam int ADDR_W        = 16;
	localparam int BANK_W        = 3;
	localparam int BANKS         = 8;
	localparam int AP_BIT        = 10;
	localparam int BC_BIT        = 12;
	localparam int RFU_LO        = 13;
	localparam int MR0_BL_LO     = 0;
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF    = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	localparam logic [1:0] MR0_RESET = 2'h0;
	localparam int BURST8_CYCLES = 4;
	localparam int BURST4_CYCLES = 2;
	localparam int CKE_MIN_CYCLES = 3;
	localparam int ZQ_LONG_CYCLES = 16;
	localparam int ZQ_SHORT_CYCLES = 4;

	typedef enum logic [2:0] {
		CMD_NONE     = 3'h0,
		CMD_READ_AP  = 3'h1,
		CMD_ZQ_LONG  = 3'h2,
		CMD_ZQ_SHORT = 3'h3,
		CMD_MRS      = 3'h4,
		CMD_OTHER    = 3'h5
	} cmd_type;

	typedef enum logic [1:0] {
		PWR_UP     = 2'h0,
		PWR_ACT_PD = 2'h1,
		PWR_PRE_PD = 2'h3
	} pwr_type;
endpackage : cmd_decode_pkg

// ---- common/cmd_link_if.sv ----
// pin bundle between memory controller and decoder
`timescale 1ns/1ps
`default_nettype none
interface cmd_link_if;
	import cmd_decode_pkg::*;
	logic              cs_n;
	logic              ras_n;
	logic              cas_n;
	logic              we_n;
	logic              cke;
	logic              odt;
	logic [BANK_W-1:0] ba;
	logic [ADDR_W-1:0] addr;

	modport dev (input cs_n, ras_n, cas_n, we_n, cke, odt, ba, addr);
	modport ctl (output cs_n, ras_n, cas_n, we_n, cke, odt, ba, addr);
endinterface : cmd_link_if
`default_nettype wire

// ---- core/cmd_issuer.sv ----
// controller end: drives command pins from user requests
`timescale 1ns/1ps
`default_nettype none
module cmd_issuer
	import cmd_decode_pkg::*;
#(
	parameter int CKE_MIN = CKE_MIN_CYCLES
) (
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              nrst_i,
	input  wire logic              ce_i,
	// user requests
	input  wire logic              req_i,
	input  wire cmd_type           req_cmd_i,
	input  wire logic [BANK_W-1:0] req_bank_i,
	input  wire logic [12:0]       req_addr_i,
	input  wire logic              req_chop4_i,
	input  wire logic              pd_req_i,
	// status
	output logic                   ready_o,
	output logic                   pd_o,
	// link
	cmd_link_if.ctl                link
);
	typedef struct packed {
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic              cke;
		logic [BANK_W-1:0] ba;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        hold;
	} state_type;

	state_type s_reg;
	state_type s_next;
	logic      can_issue;

	always_comb begin
		s_next = s_reg;
		s_next.cs_n = 1'b1;
		s_next.ras_n = 1'b1;
		s_next.cas_n = 1'b1;
		s_next.we_n = 1'b1;
		s_next.addr = '0;
		if (s_reg.hold != 8'h00) begin
			s_next.hold = s_reg.hold - 8'h01;
		end
		can_issue = (s_reg.hold == 8'h00);
		if (can_issue && (pd_req_i != !s_reg.cke)) begin
			s_next.cke = !pd_req_i;
			s_next.hold = 8'(CKE_MIN);
		end else if (can_issue && s_reg.cke && req_i) begin
			s_next.cs_n = 1'b0;
			s_next.ba = req_bank_i;
			s_next.addr[12:0] = req_addr_i;
			unique case (req_cmd_i)
				CMD_READ_AP: begin
					s_next.cas_n = 1'b0;
					s_next.addr[AP_BIT] = 1'b1;
					s_next.addr[BC_BIT] = !req_chop4_i;
				end
				CMD_ZQ_LONG, CMD_ZQ_SHORT: begin
					s_next.we_n = 1'b0;
					s_next.addr[AP_BIT] = (req_cmd_i == CMD_ZQ_LONG);
				end
				CMD_MRS: begin
					s_next.ras_n = 1'b0;
					s_next.cas_n = 1'b0;
					s_next.we_n = 1'b0;
				end
				default: s_next.cs_n = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_reg <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
				cke: 1'b1, default: '0};
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign link.cs_n  = s_reg.cs_n;
	assign link.ras_n = s_reg.ras_n;
	assign link.cas_n = s_reg.cas_n;
	assign link.we_n  = s_reg.we_n;
	assign link.cke   = s_reg.cke;
	assign link.odt   = 1'b0;
	assign link.ba    = s_reg.ba;
	assign link.addr  = s_reg.addr;
	assign ready_o    = (s_reg.hold == 8'h00) && s_reg.cke;
	assign pd_o       = !s_reg.cke;
endmodule : cmd_issuer
`default_nettype wire

// ---- dv/cmd_link_monitor.sv ----
// assertions on the command link and decoder results
`timescale 1ns/1ps
`default_nettype none
module cmd_link_monitor
	import cmd_decode_pkg::*;
(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              nrst_i,
	// link
	input  wire logic              cs_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	input  wire logic              cke,
	input  wire logic [BANK_W-1:0] ba,
	input  wire logic [ADDR_W-1:0] addr,
	// decoder side
	input  wire logic [1:0]        mr0_bl_i,
	input  wire logic              banks_open_i,
	input  wire logic              busy_o,
	input  wire logic              read_ap_o,
	input  wire logic              read_chop4_o,
	input  wire logic [BANK_W-1:0] bank_o,
	input  wire logic              zq_long_o,
	input  wire logic              zq_short_o,
	input  wire pwr_type           pwr_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	sequence s_up; cke && $past(cke) && pwr_o == PWR_UP; endsequence
	sequence s_rd; s_up ##0 (!cs_n && ras_n && !cas_n && we_n && addr[AP_BIT]); endsequence
	sequence s_zq; s_up ##0 (!cs_n && ras_n && cas_n && !we_n); endsequence
	sequence s_nop; cs_n || (ras_n && cas_n && we_n); endsequence
	sequence s_fall; $past(cke) && !cke; endsequence
	property p_rd; s_rd |=> read_ap_o && bank_o == $past(ba); endproperty
	a_rd: assert property (p_rd) else $error("read not decoded");
	property p_chop; s_rd |=> read_chop4_o == ($past(mr0_bl_i) == BL_FIXED4
		|| ($past(mr0_bl_i) == BL_OTF && !$past(addr[BC_BIT]))); endproperty
	a_chop: assert property (p_chop) else $error("burst size wrong");
	property p_zq; s_zq |=> zq_long_o == $past(addr[AP_BIT]) && zq_short_o != zq_long_o;
	endproperty
	a_zq: assert property (p_zq) else $error("calibration wrong");
	property p_nop; s_nop |=> !read_ap_o && !zq_long_o && !zq_short_o; endproperty
	a_nop: assert property (p_nop) else $error("idle cycle decoded");
	property p_stay; !$past(cke) && !cke |=> pwr_o != PWR_UP; endproperty
	a_stay: assert property (p_stay) else $error("left power down");
	property p_exit; !$past(cke) && cke ##0 s_nop |=> pwr_o == PWR_UP; endproperty
	a_exit: assert property (p_exit) else $error("no exit");
	property p_pre; s_fall ##0 (!banks_open_i && !busy_o && pwr_o == PWR_UP)
		|=> pwr_o == PWR_PRE_PD; endproperty
	a_pre: assert property (p_pre) else $error("no precharge down");
	property p_act; s_fall ##0 s_nop ##0 banks_open_i |=> pwr_o == PWR_ACT_PD; endproperty
	a_act: assert property (p_act) else $error("no active down");
	property p_cke; $changed(cke) |=> $stable(cke) [*2]; endproperty
	a_cke: assert property (p_cke) else $error("cke pulse short");
	property p_rfu; s_rd |-> addr[ADDR_W-1:RFU_LO] == '0; endproperty
	a_rfu: assert property (p_rfu) else $error("reserved bits set");
endmodule : cmd_link_monitor
`default_nettype wire

// ---- dv/ddr3_command_cke_decoder_bench.sv ----
// self-checking bench: issuer drives decoder over the link
`timescale 1ns/1ps
`default_nettype none
module ddr3_command_cke_decoder_bench;
	import cmd_decode_pkg::*;
	logic        clock_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        req_i = 1'b0;
	cmd_type     req_cmd_i = CMD_NONE;
	logic [2:0]  req_bank_i = 3'h0;
	logic [12:0] req_addr_i = 13'h0000;
	logic        req_chop4_i = 1'b0;
	logic        pd_req_i = 1'b0;
	logic [1:0]  mr0_bl_i = BL_OTF;
	logic        banks_open_i = 1'b0;
	logic        ready_o, pd_o, read_ap_o, read_chop4_o, mrs_o, zq_long_o, zq_short_o;
	logic        busy_o, idle_o;
	logic [2:0]  bank_o;
	logic [1:0]  mrs_sel_o;
	pwr_type     pwr_o;
	int          fails = 0;
	int          samples_checked = 0;
	cmd_link_if link_if ();
	always #12.5 clock_i = ~clock_i;
	cmd_issuer cmd_issuer_inst (.clock_i, .nrst_i, .ce_i(1'b1), .req_i, .req_cmd_i,
		.req_bank_i, .req_addr_i, .req_chop4_i, .pd_req_i, .ready_o, .pd_o, .link(link_if));
	cmd_decoder cmd_decoder_inst (.clock_i, .nrst_i, .ce_i(1'b1), .link(link_if), .mr0_bl_i,
		.banks_open_i, .read_ap_o, .read_chop4_o, .bank_o, .mrs_o, .mrs_sel_o, .zq_long_o,
		.zq_short_o, .busy_o, .idle_o, .pwr_o);
	cmd_link_monitor cmd_link_monitor_inst (.clock_i, .nrst_i, .cs_n(link_if.cs_n),
		.ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n), .cke(link_if.cke),
		.ba(link_if.ba), .addr(link_if.addr), .mr0_bl_i, .banks_open_i, .busy_o, .read_ap_o,
		.read_chop4_o, .bank_o, .zq_long_o, .zq_short_o, .pwr_o);
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic summarize();
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic await(ref logic s, input logic v, input string what);
		int n;
		for (n = 0; n < 40 && s !== v; n++)
			@(negedge clock_i);
		chk(what, s, v);
		if (s !== v)
			summarize();
	endtask : await
	task automatic issue(cmd_type c, logic [2:0] b, logic ch);
		await(ready_o, 1'b1, "ready");
		@(posedge clock_i);
		{req_i, req_cmd_i, req_bank_i, req_addr_i, req_chop4_i} <= {1'b1, c, b, 13'h0400, ch};
		@(posedge clock_i);
		req_i <= 1'b0;
	endtask : issue
	task automatic t_reads();
		for (int m = 0; m < 3; m++) begin
			for (int ch = 0; ch < 2; ch++) begin
				mr0_bl_i <= 2'(m);
				issue(CMD_READ_AP, 3'(m * 2 + ch), ch[0]);
				await(read_ap_o, 1'b1, "read");
				chk("chop", read_chop4_o, m == 2 || (m == 1 && ch == 1));
				chk("busy", busy_o, 8'h01);
				chk("bank", bank_o, 8'(m * 2 + ch));
			end
		end
	endtask : t_reads
	task automatic t_zq();
		issue(CMD_ZQ_LONG, 3'h0, 1'b0);
		await(zq_long_o, 1'b1, "zq long");
		issue(CMD_ZQ_SHORT, 3'h0, 1'b0);
		await(zq_short_o, 1'b1, "zq short");
	endtask : t_zq
	task automatic t_mrs();
		issue(CMD_MRS, 3'h6, 1'b0);
		await(mrs_o, 1'b1, "mrs");
		chk("mrs sel", mrs_sel_o, 8'h02);
	endtask : t_mrs
	task automatic t_pd(logic open, pwr_type exp);
		banks_open_i <= open;
		await(busy_o, 1'b0, "busy");
		@(posedge clock_i);
		pd_req_i <= 1'b1;
		await(pd_o, 1'b1, "cke low");
		chk("idle", idle_o, !open);
		@(negedge clock_i);
		chk("pwr down", pwr_o, exp);
		@(posedge clock_i);
		pd_req_i <= 1'b0;
		await(pd_o, 1'b0, "cke high");
		@(negedge clock_i);
		chk("pwr up", pwr_o, PWR_UP);
	endtask : t_pd
	initial begin
		repeat (10) @(posedge clock_i);
		nrst_i <= 1'b1;
		t_reads();
		t_zq();
		t_mrs();
		t_pd(1'b0, PWR_PRE_PD);
		t_pd(1'b1, PWR_ACT_PD);
		summarize();
	end
endmodule : ddr3_command_cke_decoder_bench
`default_nettype wire
